/* File: logic/ssc_pkg.sv */
`default_nettype none
package ssc_pkg;
  // register index on the plain register port
  localparam logic [3:0] SSC_OFS_STATUS = 4'h0;
  localparam logic [3:0] SSC_OFS_CONTROL = 4'h1;
  localparam logic [3:0] SSC_OFS_RELOAD = 4'h2;
  localparam logic [3:0] SSC_OFS_BUFFER = 4'h3;
  // status field positions
  localparam int SSC_ST_SAMPLE = 7;
  localparam int SSC_ST_EDGE = 6;
  localparam int SSC_ST_DATA = 5;
  localparam int SSC_ST_STOP = 4;
  localparam int SSC_ST_START = 3;
  localparam int SSC_ST_RW = 2;
  localparam int SSC_ST_UA = 1;
  localparam int SSC_ST_BF = 0;
  // control field positions
  localparam int SSC_CT_WRITE_COLLISION_FLAG = 7;
  localparam int SSC_CT_OV = 6;
  localparam int SSC_CT_EN = 5;
  localparam int SSC_CT_CKP = 4;
  // reset values
  localparam logic [7:0] SSC_STATUS_RST = 8'h00;
  localparam logic [7:0] SSC_CONTROL_RST = 8'h00;
  localparam logic [7:0] SSC_RELOAD_RST = 8'h00;
  localparam logic [7:0] SSC_BUFFER_RST = 8'h00;
  // mode field encodings
  localparam logic [3:0] SSC_M_SPI_H4 = 4'h0;
  localparam logic [3:0] SSC_M_SPI_H16 = 4'h1;
  localparam logic [3:0] SSC_M_SPI_H64 = 4'h2;
  localparam logic [3:0] SSC_M_SPI_HTMR = 4'h3;
  localparam logic [3:0] SSC_M_SPI_C_SS = 4'h4;
  localparam logic [3:0] SSC_M_SPI_C_NOSS = 4'h5;
  localparam logic [3:0] SSC_M_I2C_C7 = 4'h6;
  localparam logic [3:0] SSC_M_I2C_C10 = 4'h7;
  localparam logic [3:0] SSC_M_I2C_HBRG = 4'h8;
  localparam logic [3:0] SSC_M_SPI_HBRG = 4'ha;
  localparam logic [3:0] SSC_M_I2C_HFW = 4'hb;
  localparam logic [3:0] SSC_M_I2C_C7SP = 4'he;
  localparam logic [3:0] SSC_M_I2C_C10SP = 4'hf;
  // serial clock half periods in system clocks
  localparam logic [8:0] SSC_HALF_DIV4 = 9'h002;
  localparam logic [8:0] SSC_HALF_DIV16 = 9'h008;
  localparam logic [8:0] SSC_HALF_DIV64 = 9'h020;

  typedef enum logic {SSC_BRG_IDLE, SSC_BRG_RUN} ssc_brg_t;

  typedef struct packed {
    logic rx_done;
    logic [7:0] rx_data;
    logic tx_done;
    logic byte_is_data;
    logic start_seen;
    logic stop_seen;
    logic nack_seen;
    logic addr_match;
    logic addr_rw;
    logic addr_update_req;
    logic shifting;
    logic host_tx_active;
    logic [4:0] host_seq;
    logic xfer_done;
    logic timer_two_tick;
  } ssc_evt_t;

  typedef struct packed {
    logic pins_owned;
    logic ss_used;
    logic spi_sample_end;
    logic spi_launch_idle_edge;
    logic spi_idle_high;
    logic i2c_slew_en;
    logic i2c_smbus;
    logic i2c_scl_release;
    logic serial_clk;
    logic serial_clk_edge;
    logic busy;
    logic tx_load;
    logic [7:0] tx_data;
    logic [3:0] mode;
  } ssc_ctl_t;

  function automatic logic ssc_is_i2c(input logic [3:0] m);
    return m inside {SSC_M_I2C_C7, SSC_M_I2C_C10, SSC_M_I2C_HBRG, SSC_M_I2C_HFW,
                     SSC_M_I2C_C7SP, SSC_M_I2C_C10SP};
  endfunction

  function automatic logic ssc_is_spi(input logic [3:0] m);
    return (m <= SSC_M_SPI_C_NOSS) || (m == SSC_M_SPI_HBRG);
  endfunction

  function automatic logic ssc_is_host(input logic [3:0] m);
    return (m <= SSC_M_SPI_HTMR) || m inside {SSC_M_I2C_HBRG, SSC_M_SPI_HBRG, SSC_M_I2C_HFW};
  endfunction
endpackage
`default_nettype wire

/* File: logic/ssc_core.sv */
// Function
// - hbrg modes: host clock is osc over 4(reload+1)
// - buffer write starts generator, done stops it
// - spi host samples at end or middle
// - i2c sample bit toggles slew rate control
// - spi edge bit picks launch clock transition
// - i2c edge bit selects smbus input thresholds
// - data flag marks last byte as data
// - stop and start flags show latest condition
// - client read/write flag holds matched direction
// - host read/write flag shows transmit, feeds busy
// - ten-bit client raises update address flag
// - buffer full sets on receive, clears when empty
// - i2c transmit buffer full spans data byte
// - write collision flag set, software clears it
// - spi client overflow loses new byte
// - i2c overflow on receive while buffer full
// - port enable hands pins to the port
// - spi clock polarity sets idle level
// - i2c client polarity bit releases clock line
// - mode field selects spi host and client modes
// - mode field selects i2c client and host modes
`default_nettype none
module ssc_core (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire ssc_pkg::ssc_evt_t evt,
  output ssc_pkg::ssc_ctl_t ctl
);
  import ssc_pkg::*;

  typedef struct packed {
    ssc_ctl_t ctl;
    logic [7:0] rdata;
    logic [7:0] status;
    logic [7:0] control;
    logic [7:0] reload;
    logic [7:0] rxbuf;
    logic bf_tx;
    ssc_brg_t baud_reload_counter;
    logic [8:0] cnt;
  } ssc_state_t;

  localparam ssc_ctl_t SSC_CTL_RST = '0;
  localparam ssc_state_t SSC_STATE_RST = '{
    ctl: SSC_CTL_RST,
    rdata: 8'h00,
    status: SSC_STATUS_RST,
    control: SSC_CONTROL_RST,
    reload: SSC_RELOAD_RST,
    rxbuf: SSC_BUFFER_RST,
    bf_tx: 1'b0,
    baud_reload_counter: SSC_BRG_IDLE,
    cnt: 9'h000
  };

  ssc_state_t st_ff;
  ssc_state_t nxt_st;

  // reload count for one half period of the host clock
  function automatic logic [8:0] half_load(input logic [3:0] m, input logic [7:0] rl);
    logic [8:0] h;
    h = SSC_HALF_DIV4;
    case (m)
      SSC_M_SPI_H16: h = SSC_HALF_DIV16;
      SSC_M_SPI_H64: h = SSC_HALF_DIV64;
      default: h = SSC_HALF_DIV4;
    endcase
    if (m == SSC_M_SPI_HBRG || m == SSC_M_I2C_HBRG) begin
      return {rl, 1'b1};
    end
    return 9'(h - 9'h001);
  endfunction

  logic [3:0] mode;
  logic en;
  logic i2c;
  logic spi;
  logic host;
  logic spi_client;
  logic ten_bit;
  logic brg_mode;
  logic host_busy;
  logic collide;
  logic buf_wr;
  logic buf_rd;
  logic rx_take;

  always_comb begin
    mode = st_ff.control[3:0];
    en = st_ff.control[SSC_CT_EN];
    i2c = ssc_is_i2c(mode);
    spi = ssc_is_spi(mode);
    host = ssc_is_host(mode);
    spi_client = (mode == SSC_M_SPI_C_SS) || (mode == SSC_M_SPI_C_NOSS);
    ten_bit = (mode == SSC_M_I2C_C10) || (mode == SSC_M_I2C_C10SP);
    brg_mode = host && (mode != SSC_M_I2C_HFW);
    host_busy = evt.host_tx_active || (|evt.host_seq) || (st_ff.baud_reload_counter == SSC_BRG_RUN);
    buf_wr = reg_wr && (reg_addr == SSC_OFS_BUFFER);
    buf_rd = reg_rd && (reg_addr == SSC_OFS_BUFFER);
    collide = buf_wr && en && (host ? host_busy : evt.shifting);
    rx_take = evt.rx_done && en;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ctl.tx_load = 1'b0;
    nxt_st.ctl.serial_clk_edge = 1'b0;
    nxt_st.rdata = 8'h00;

    // software reads, data one cycle later
    if (reg_rd) begin
      case (reg_addr)
        SSC_OFS_STATUS: nxt_st.rdata = st_ff.status;
        SSC_OFS_CONTROL: nxt_st.rdata = st_ff.control;
        SSC_OFS_RELOAD: nxt_st.rdata = st_ff.reload;
        SSC_OFS_BUFFER: nxt_st.rdata = st_ff.rxbuf;
        default: nxt_st.rdata = 8'h00;
      endcase
    end

    // software writes
    if (reg_wr) begin
      case (reg_addr)
        SSC_OFS_STATUS: begin
          nxt_st.status[SSC_ST_SAMPLE] = reg_wdata[SSC_ST_SAMPLE];
          nxt_st.status[SSC_ST_EDGE] = reg_wdata[SSC_ST_EDGE];
        end
        SSC_OFS_CONTROL: begin
          nxt_st.control[SSC_CT_WRITE_COLLISION_FLAG] = st_ff.control[SSC_CT_WRITE_COLLISION_FLAG]
                                        & reg_wdata[SSC_CT_WRITE_COLLISION_FLAG];
          nxt_st.control[SSC_CT_OV] = st_ff.control[SSC_CT_OV]
                                      & reg_wdata[SSC_CT_OV];
          nxt_st.control[SSC_CT_EN] = reg_wdata[SSC_CT_EN];
          nxt_st.control[SSC_CT_CKP] = reg_wdata[SSC_CT_CKP];
          nxt_st.control[3:0] = reg_wdata[3:0];
        end
        SSC_OFS_RELOAD: begin
          nxt_st.reload = reg_wdata;
          nxt_st.status[SSC_ST_UA] = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // reading the buffer empties it on the receive side
    if (buf_rd && !st_ff.bf_tx) begin
      nxt_st.status[SSC_ST_BF] = 1'b0;
    end

    // buffer write: collision or transmit load
    if (collide) begin
      nxt_st.control[SSC_CT_WRITE_COLLISION_FLAG] = 1'b1;
    end else if (buf_wr && en) begin
      nxt_st.ctl.tx_load = 1'b1;
      nxt_st.ctl.tx_data = reg_wdata;
      if (i2c) begin
        nxt_st.status[SSC_ST_BF] = 1'b1;
        nxt_st.bf_tx = 1'b1;
      end
      if (brg_mode) begin
        nxt_st.baud_reload_counter = SSC_BRG_RUN;
        nxt_st.cnt = half_load(mode, st_ff.reload);
        if (spi) begin
          nxt_st.ctl.serial_clk = st_ff.control[SSC_CT_CKP];
        end
      end
    end

    // transmitted data byte done, ack and stop excluded
    if (evt.tx_done && en) begin
      if (st_ff.bf_tx) begin
        nxt_st.status[SSC_ST_BF] = 1'b0;
        nxt_st.bf_tx = 1'b0;
      end
      if (i2c) begin
        nxt_st.status[SSC_ST_DATA] = evt.byte_is_data;
      end
    end

    // received byte
    if (rx_take) begin
      if (i2c) begin
        nxt_st.status[SSC_ST_DATA] = evt.byte_is_data;
      end
      if (st_ff.status[SSC_ST_BF] && !st_ff.bf_tx && !buf_rd) begin
        if (spi_client || i2c) begin
          nxt_st.control[SSC_CT_OV] = 1'b1;
        end else begin
          nxt_st.rxbuf = evt.rx_data;
          nxt_st.status[SSC_ST_BF] = 1'b1;
        end
      end else begin
        nxt_st.rxbuf = evt.rx_data;
        nxt_st.status[SSC_ST_BF] = 1'b1;
        nxt_st.bf_tx = 1'b0;
      end
    end

    // bus conditions
    if (en && i2c) begin
      if (evt.start_seen) begin
        nxt_st.status[SSC_ST_START] = 1'b1;
        nxt_st.status[SSC_ST_STOP] = 1'b0;
      end
      if (evt.stop_seen) begin
        nxt_st.status[SSC_ST_STOP] = 1'b1;
        nxt_st.status[SSC_ST_START] = 1'b0;
      end
      if (host) begin
        nxt_st.status[SSC_ST_RW] = evt.host_tx_active;
      end else begin
        if (evt.start_seen || evt.stop_seen || evt.nack_seen) begin
          nxt_st.status[SSC_ST_RW] = 1'b0;
        end
        if (evt.addr_match) begin
          nxt_st.status[SSC_ST_RW] = evt.addr_rw;
        end
      end
      if (ten_bit && evt.addr_update_req) begin
        nxt_st.status[SSC_ST_UA] = 1'b1;
      end
    end

    // disabled port forgets bus conditions
    if (!en) begin
      nxt_st.status[SSC_ST_START] = 1'b0;
      nxt_st.status[SSC_ST_STOP] = 1'b0;
    end

    // host clock generator
    case (st_ff.baud_reload_counter)
      SSC_BRG_IDLE: begin
        if (en && spi && !(buf_wr && !collide)) begin
          nxt_st.ctl.serial_clk = st_ff.control[SSC_CT_CKP];
        end
      end
      SSC_BRG_RUN: begin
        if (!en || !brg_mode || evt.xfer_done) begin
          nxt_st.baud_reload_counter = SSC_BRG_IDLE;
        end else if (mode == SSC_M_SPI_HTMR) begin
          if (evt.timer_two_tick) begin
            nxt_st.ctl.serial_clk = !st_ff.ctl.serial_clk;
            nxt_st.ctl.serial_clk_edge = 1'b1;
          end
        end else if (st_ff.cnt == 9'h000) begin
          nxt_st.ctl.serial_clk = !st_ff.ctl.serial_clk;
          nxt_st.ctl.serial_clk_edge = 1'b1;
          nxt_st.cnt = half_load(mode, st_ff.reload);
        end else begin
          nxt_st.cnt = 9'(st_ff.cnt - 9'h001);
        end
      end
      default: nxt_st.baud_reload_counter = SSC_BRG_IDLE;
    endcase

    // pin and mode controls from the new configuration
    nxt_st.ctl.mode = nxt_st.control[3:0];
    nxt_st.ctl.pins_owned = nxt_st.control[SSC_CT_EN];
    nxt_st.ctl.ss_used = nxt_st.control[SSC_CT_EN]
                         && (nxt_st.control[3:0] == SSC_M_SPI_C_SS);
    nxt_st.ctl.spi_sample_end = nxt_st.status[SSC_ST_SAMPLE]
                                && ssc_is_spi(nxt_st.control[3:0])
                                && ssc_is_host(nxt_st.control[3:0]);
    nxt_st.ctl.spi_launch_idle_edge = nxt_st.status[SSC_ST_EDGE]
                                      && ssc_is_spi(nxt_st.control[3:0]);
    nxt_st.ctl.spi_idle_high = nxt_st.control[SSC_CT_CKP]
                               && ssc_is_spi(nxt_st.control[3:0]);
    nxt_st.ctl.i2c_slew_en = !nxt_st.status[SSC_ST_SAMPLE]
                             && ssc_is_i2c(nxt_st.control[3:0]);
    nxt_st.ctl.i2c_smbus = nxt_st.status[SSC_ST_EDGE]
                           && ssc_is_i2c(nxt_st.control[3:0]);
    if (ssc_is_i2c(nxt_st.control[3:0]) && !ssc_is_host(nxt_st.control[3:0])) begin
      nxt_st.ctl.i2c_scl_release = nxt_st.control[SSC_CT_CKP];
    end else begin
      nxt_st.ctl.i2c_scl_release = 1'b1;
    end
    nxt_st.ctl.busy = evt.host_tx_active || (|evt.host_seq);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= SSC_STATE_RST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign ctl = st_ff.ctl;
endmodule
`default_nettype wire

/* File: tb/ssc_core_props.sv */
`default_nettype none
module ssc_core_props (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire ssc_pkg::ssc_evt_t evt,
  input wire ssc_pkg::ssc_ctl_t ctl
);
  timeunit 1ns;
  timeprecision 100ps;
  import ssc_pkg::*;
  logic [7:0] rel_ff;
  int cnt_ff;
  logic seen_ff;
  int half;
  logic wr_st;
  logic wr_ct;
  function automatic logic spi_m(input logic [3:0] m);
    return m <= 4'h5 || m == 4'ha;
  endfunction
  function automatic logic i2c_m(input logic [3:0] m);
    return m inside {4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf};
  endfunction
  assign wr_st = reg_wr && reg_addr == SSC_OFS_STATUS;
  assign wr_ct = reg_wr && reg_addr == SSC_OFS_CONTROL;
  always_comb begin
    case (ctl.mode)
      4'h0: half = 2;
      4'h1: half = 8;
      4'h2: half = 32;
      default: half = 2 * (int'(rel_ff) + 1);
    endcase
  end
  // clocks since the last serial clock toggle within one run
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rel_ff <= 8'h00;
      cnt_ff <= 0;
      seen_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == SSC_OFS_RELOAD) rel_ff <= reg_wdata;
      cnt_ff <= ctl.serial_clk_edge ? 1 : cnt_ff + 1;
      seen_ff <= evt.host_tx_active && !ctl.tx_load && (seen_ff || ctl.serial_clk_edge);
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_enable_pins: assert property (wr_ct |=> ctl.pins_owned == $past(reg_wdata[SSC_CT_EN]))
    else $error("port enable not applied");
  a_mode_select: assert property (wr_ct |=> ctl.mode == $past(reg_wdata[3:0]))
    else $error("mode field not applied");
  a_idle_level: assert property (wr_ct |=>
    ctl.spi_idle_high == ($past(reg_wdata[SSC_CT_CKP]) && spi_m(ctl.mode)))
    else $error("idle clock level wrong");
  a_scl_release: assert property (wr_ct && reg_wdata[3:0] inside {4'h6, 4'h7, 4'he, 4'hf} |=>
    ctl.i2c_scl_release == $past(reg_wdata[SSC_CT_CKP]))
    else $error("clock release wrong");
  a_spi_phase: assert property (wr_st |=>
    ctl.spi_launch_idle_edge == ($past(reg_wdata[SSC_ST_EDGE]) && spi_m(ctl.mode)) &&
    ctl.spi_sample_end == ($past(reg_wdata[SSC_ST_SAMPLE]) && (ctl.mode <= 4'h3 || ctl.mode == 4'ha)))
    else $error("spi phase controls wrong");
  a_i2c_inputs: assert property (wr_st |=>
    ctl.i2c_smbus == ($past(reg_wdata[SSC_ST_EDGE]) && i2c_m(ctl.mode)) &&
    ctl.i2c_slew_en == (!$past(reg_wdata[SSC_ST_SAMPLE]) && i2c_m(ctl.mode)))
    else $error("i2c input controls wrong");
  a_busy_or: assert property (ctl.busy == $past(evt.host_tx_active || (|evt.host_seq)))
    else $error("busy not the or of host activity");
  a_tx_accept: assert property (ctl.tx_load |->
    $past(reg_wr && reg_addr == SSC_OFS_BUFFER) && ctl.tx_data == $past(reg_wdata))
    else $error("load without buffer write");
  a_clk_half: assert property (ctl.serial_clk_edge && seen_ff && evt.host_tx_active &&
    ctl.mode inside {4'h0, 4'h1, 4'h2, 4'h8, 4'ha} |-> cnt_ff == half)
    else $error("serial clock half period wrong");
  a_timer_clock: assert property (ctl.mode == 4'h3 && ctl.pins_owned &&
    evt.timer_two_tick && evt.host_tx_active && !evt.xfer_done |=> ctl.serial_clk_edge)
    else $error("timer tick did not toggle serial clock");
  a_select_use: assert property (wr_ct |=>
    ctl.ss_used == ($past(reg_wdata[SSC_CT_EN]) && ctl.mode == 4'h4))
    else $error("select pin use wrong");
endmodule
`default_nettype wire

/* File: tb/ssc_engine_model.sv */
`default_nettype none
module ssc_engine_model #(
  parameter int SPAN = 200
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire ssc_pkg::ssc_ctl_t ctl,
  input wire ssc_pkg::ssc_evt_t ext,
  output var ssc_pkg::ssc_evt_t evt
);
  timeunit 1ns;
  timeprecision 100ps;
  import ssc_pkg::*;
  int left_ff;
  // a transfer lasts span clocks after each accepted load
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      left_ff <= 0;
    end else if (ctl.tx_load) begin
      left_ff <= SPAN;
    end else if (left_ff > 0) begin
      left_ff <= left_ff - 1;
    end
  end
  always_comb begin
    evt = ext;
    evt.shifting = ext.shifting | (left_ff > 0);
    evt.host_tx_active = ext.host_tx_active | (left_ff > 0);
    evt.tx_done = ext.tx_done | (left_ff == 1);
    evt.xfer_done = ext.xfer_done | (left_ff == 1);
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ssc_pkg::*;
  logic clk_sys;
  logic rst_b;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  ssc_evt_t ext;
  ssc_evt_t evt;
  ssc_ctl_t ctl;
  int n_mismatch;
  int checks_done;
  int seed;
  ssc_core ssc_core_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .evt(evt), .ctl(ctl));
  ssc_engine_model #(.SPAN(200)) ssc_engine_model_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .ctl(ctl), .ext(ext), .evt(evt));
  function automatic int rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed & 32'h7fffffff;
  endfunction
  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] mk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata & mk, e & mk);
    @(posedge clk_sys);
  endtask
  task automatic ev(input int k, input logic [7:0] d);
    ssc_evt_t e;
    e = '0;
    e.host_seq = 5'(rnd());
    case (k)
      0: begin
        e.rx_done = 1'b1;
        e.rx_data = d;
        e.byte_is_data = 1'b1;
      end
      1: e.start_seen = 1'b1;
      2: e.stop_seen = 1'b1;
      3: begin
        e.addr_match = 1'b1;
        e.addr_rw = d[0];
      end
      default: e.addr_update_req = 1'b1;
    endcase
    ext <= e;
    @(posedge clk_sys);
    ext <= '0;
    @(posedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (6000) @(posedge clk_sys);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    logic [7:0] v;
    logic [7:0] sv;
    logic [7:0] d1;
    logic [3:0] m;
    logic ovx;
    logic s;
    seed = 90162;
    n_mismatch = 0;
    checks_done = 0;
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext = '0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a < 8; a++) rd(4'(a), 8'h00, 8'hff);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00, 8'hff);
    // every defined mode code (9, c and d skipped) with random polarity, enable and phase bits
    for (int i = 0; i < 16; i++) begin
      m = 4'(i);
      if (m inside {4'h9, 4'hc, 4'hd}) continue;
      v = 8'(rnd());
      sv = {v[7] & (m != 4'h4) & (m != 4'h5), v[6], 6'h00};
      wr(SSC_OFS_CONTROL, {2'b00, v[5:4], m});
      wr(SSC_OFS_STATUS, sv | 8'h3f);
      rd(SSC_OFS_CONTROL, {2'b00, v[5:4], m}, 8'hff);
      rd(SSC_OFS_STATUS, sv, 8'hff);
    end
    wr(SSC_OFS_STATUS, 8'h00);
    // two bytes arrive without a read in between
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? SSC_M_SPI_C_NOSS : (i == 1) ? SSC_M_SPI_H4 : SSC_M_I2C_C7;
      ovx = (m != SSC_M_SPI_H4);
      d1 = 8'(rnd());
      wr(SSC_OFS_CONTROL, {4'h2, m});
      ev(0, d1);
      ev(0, ~d1);
      rd(SSC_OFS_STATUS, 8'h01, 8'h01);
      rd(SSC_OFS_CONTROL, {1'b0, ovx, 6'h00}, 8'h40);
      rd(SSC_OFS_BUFFER, ovx ? d1 : ~d1, 8'hff);
      rd(SSC_OFS_STATUS, 8'h00, 8'h01);
      wr(SSC_OFS_CONTROL, {4'h2, m});
      rd(SSC_OFS_CONTROL, {4'h2, m}, 8'hff);
    end
    // bus conditions in ten-bit client mode
    wr(SSC_OFS_CONTROL, {4'h2, SSC_M_I2C_C10});
    ev(1, 8'h00);
    rd(SSC_OFS_STATUS, 8'h08, 8'h18);
    ev(3, 8'h01);
    rd(SSC_OFS_STATUS, 8'h04, 8'h04);
    ev(0, 8'h5a);
    rd(SSC_OFS_STATUS, 8'h21, 8'h21);
    ev(4, 8'h00);
    rd(SSC_OFS_STATUS, 8'h02, 8'h02);
    wr(SSC_OFS_RELOAD, 8'h10);
    rd(SSC_OFS_STATUS, 8'h00, 8'h02);
    ev(2, 8'h00);
    rd(SSC_OFS_STATUS, 8'h10, 8'h18);
    rd(SSC_OFS_BUFFER, 8'h5a, 8'hff);
    wr(SSC_OFS_CONTROL, {4'h0, SSC_M_I2C_C10});
    rd(SSC_OFS_STATUS, 8'h00, 8'h18);
    // host clocking and one spi client mode, second write collides while running
    for (int i = 0; i < 7; i++) begin
      m = (i < 4) ? 4'(i) : (i == 4) ? SSC_M_SPI_HBRG
        : (i == 5) ? SSC_M_I2C_HBRG : SSC_M_SPI_C_NOSS;
      ext.timer_two_tick <= (m == SSC_M_SPI_HTMR);
      v = 8'(3 + rnd() % 6);
      wr(SSC_OFS_RELOAD, v);
      wr(SSC_OFS_CONTROL, {4'h2, m});
      d1 = 8'(rnd());
      wr(SSC_OFS_BUFFER, d1);
      wr(SSC_OFS_BUFFER, ~d1);
      rd(SSC_OFS_CONTROL, 8'h80, 8'h80);
      if (m == SSC_M_I2C_HBRG) rd(SSC_OFS_STATUS, 8'h05, 8'h05);
      repeat (200) @(posedge clk_sys);
      if (m == SSC_M_I2C_HBRG) rd(SSC_OFS_STATUS, 8'h00, 8'h05);
      #1;
      s = ctl.serial_clk;
      repeat (20) begin
        @(posedge clk_sys);
        #1;
        cmp({6'h00, ctl.serial_clk_edge, ctl.serial_clk}, {7'h00, s});
      end
      @(posedge clk_sys);
      wr(SSC_OFS_CONTROL, {4'h2, m});
      rd(SSC_OFS_CONTROL, {4'h2, m}, 8'hff);
    end
    give_verdict();
  end
endmodule
bind ssc_core ssc_core_props ssc_core_props_i (.clk_sys(clk_sys), .rst_b(rst_b),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .ctl(ctl));
`default_nettype wire
